// >>> psrc_top.sv
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/100ps
module psrc_top #(
  parameter logic [31:0] CAP_FOUR_VAL = psrc_pkg::CAP_FOUR_RST
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output psrc_pkg::psrc_resets_t periph_rst
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic aw_have;
    logic [11:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl_one;
    logic [31:0] ctrl_two;
    psrc_pkg::psrc_resets_t rst_out;
    // Readies kept as flops so no port sits behind a gate
    logic aw_free;
    logic w_free;
    logic ar_free;
  } psrc_state_t;

  psrc_state_t st_r;
  psrc_state_t st_nxt;
  logic [31:0] cap_four;
  logic [31:0] strb_mask;
  logic [31:0] wr_mask;
  logic do_write;
  logic [11:0] wr_word;
  logic [11:0] rd_word;
  logic wr_mapped;

  // Word addresses; byte-lane bits 1:0 never pick a register
  assign wr_word = {st_r.aw_addr[11:2], 2'h0};
  assign rd_word = {s_axi_araddr[11:2], 2'h0};
  // Only the checks read this, to tell an unmapped write apart
  assign wr_mapped = (wr_word == psrc_pkg::OFS_CTRL_ONE)
                     || (wr_word == psrc_pkg::OFS_CTRL_TWO)
                     || (wr_word == psrc_pkg::OFS_CAP_FOUR);

  // Capability mask is a build-time constant
  assign cap_four = CAP_FOUR_VAL;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    strb_mask = {{8{st_r.w_strb[3]}}, {8{st_r.w_strb[2]}},
                 {8{st_r.w_strb[1]}}, {8{st_r.w_strb[0]}}};
    wr_mask = 32'h00000000;
    do_write = st_r.aw_have && st_r.w_have && !st_r.bvalid;
    // Address and data accepted in either order
    if (s_axi_awvalid && !st_r.aw_have)
    begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && !st_r.w_have)
    begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = psrc_pkg::RESP_OKAY;
      case (wr_word)
        psrc_pkg::OFS_CTRL_ONE:
        begin
          wr_mask = strb_mask & psrc_pkg::CTRL_ONE_WMASK;
          st_nxt.ctrl_one = (st_r.ctrl_one & ~wr_mask)
                            | (st_r.w_data & wr_mask);
        end
        psrc_pkg::OFS_CTRL_TWO:
        begin
          // Masked-off bits keep their value
          wr_mask = strb_mask & psrc_pkg::CTRL_TWO_WMASK
                    & cap_four;
          st_nxt.ctrl_two = (st_r.ctrl_two & ~wr_mask)
                            | (st_r.w_data & wr_mask);
        end
        psrc_pkg::OFS_CAP_FOUR:
        begin
          wr_mask = 32'h00000000; // Read-only, write dropped
        end
        default:
        begin
          st_nxt.bresp = psrc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    // Read path, one read in flight
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rvalid)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = psrc_pkg::RESP_OKAY;
      case (rd_word)
        psrc_pkg::OFS_CTRL_ONE: st_nxt.rdata = st_r.ctrl_one;
        psrc_pkg::OFS_CTRL_TWO: st_nxt.rdata = st_r.ctrl_two;
        psrc_pkg::OFS_CAP_FOUR: st_nxt.rdata = cap_four;
        default:
        begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.rresp = psrc_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Readies follow the next parked state, so a beat drops its
    // ready on the very edge that takes it
    st_nxt.aw_free = !st_nxt.aw_have;
    st_nxt.w_free = !st_nxt.w_have;
    st_nxt.ar_free = !st_nxt.rvalid;
    // Reset lines follow stored bits, one cycle later
    st_nxt.rst_out.ether_phy =
      st_r.ctrl_two[psrc_pkg::BIT_ETHER_PHY];
    st_nxt.rst_out.ether_mac =
      st_r.ctrl_two[psrc_pkg::BIT_ETHER_MAC];
    st_nxt.rst_out.port = st_r.ctrl_two[psrc_pkg::BIT_PORT_H:
                                        psrc_pkg::BIT_PORT_A];
    st_nxt.rst_out.twowire_zero =
      st_r.ctrl_one[psrc_pkg::BIT_TWOWIRE_ZERO];
    st_nxt.rst_out.syncserial =
      {st_r.ctrl_one[psrc_pkg::BIT_SYNCSERIAL_ONE],
       st_r.ctrl_one[psrc_pkg::BIT_SYNCSERIAL_ZERO]};
    st_nxt.rst_out.async_serial =
      {st_r.ctrl_one[psrc_pkg::BIT_ASYNC_TWO],
       st_r.ctrl_one[psrc_pkg::BIT_ASYNC_ONE],
       st_r.ctrl_one[psrc_pkg::BIT_ASYNC_ZERO]};
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.ctrl_one <= psrc_pkg::CTRL_ONE_RST;
      st_r.ctrl_two <= psrc_pkg::CTRL_TWO_RST;
      st_r.aw_free <= 1'b1;
      st_r.w_free <= 1'b1;
      st_r.ar_free <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Ready held low while a beat is parked, giving back-pressure
  assign s_axi_awready = st_r.aw_free;
  assign s_axi_wready = st_r.w_free;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.ar_free;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign periph_rst = st_r.rst_out;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Second-register bits outside the capability mask never move
  a_two_masked: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ((st_r.ctrl_two ^ $past(st_r.ctrl_two)) & ~cap_four) == 32'h0)
    else $error("masked bit of second register changed");
  a_two_reserved: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (st_r.ctrl_two & ~psrc_pkg::CTRL_TWO_WMASK) == 32'h0)
    else $error("reserved bit set in second register");
  a_one_reserved: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (st_r.ctrl_one & ~psrc_pkg::CTRL_ONE_WMASK) == 32'h0)
    else $error("reserved bit set in first register");
  // No disable here: it must look at the edge right after reset
  a_reset_zero: assert property (
    @(posedge mclk)
    $past(sys_rst) |-> st_r.ctrl_two == 32'h0 && st_r.ctrl_one == 32'h0)
    else $error("registers not zero after reset");
  // Each line repeats its stored bit one edge later
  a_phy_follow: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ##1 periph_rst.ether_phy == $past(st_r.ctrl_two[30]))
    else $error("phy reset does not follow its bit");
  a_mac_follow: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ##1 periph_rst.ether_mac == $past(st_r.ctrl_two[28]))
    else $error("mac reset does not follow its bit");
  a_port_follow: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ##1 periph_rst.port == $past(st_r.ctrl_two[7:0]))
    else $error("port resets do not follow bits");
  a_twowire_follow: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ##1 periph_rst.twowire_zero == $past(st_r.ctrl_one[12]))
    else $error("two-wire reset does not follow bit");
  a_sync_follow: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ##1 periph_rst.syncserial == $past({st_r.ctrl_one[5], st_r.ctrl_one[4]}))
    else $error("sync serial resets do not follow");
  a_async_follow: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ##1 periph_rst.async_serial == $past(st_r.ctrl_one[2:0]))
    else $error("async serial resets do not follow");
  // A held bit keeps its unit in reset, a cleared one lets it go
  a_hold_reset: assert property (
    @(posedge mclk) disable iff (sys_rst)
    st_r.ctrl_two[30] && !do_write |=> ##1 periph_rst.ether_phy)
    else $error("phy released while bit held");
  a_hold_mac: assert property (
    @(posedge mclk) disable iff (sys_rst)
    st_r.ctrl_two[28] && !do_write |=> ##1 periph_rst.ether_mac)
    else $error("mac released while bit held");
  a_release_phy: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !st_r.ctrl_two[30] && !do_write |=> ##1 !periph_rst.ether_phy)
    else $error("phy held after its bit cleared");
  a_release_port: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !st_r.ctrl_two[0] && !do_write |=> ##1 !periph_rst.port[0])
    else $error("port A held after its bit cleared");

  // ------------------------------------------------------------
  // Bus checks
  // ------------------------------------------------------------
  // Full-word writes land on the writable bits only
  a_one_lands: assert property (
    @(posedge mclk) disable iff (sys_rst)
    do_write && wr_word == psrc_pkg::OFS_CTRL_ONE && st_r.w_strb == 4'hF
    |=> st_r.ctrl_one == ($past(st_r.w_data) & psrc_pkg::CTRL_ONE_WMASK))
    else $error("first register write did not land");
  a_two_lands: assert property (
    @(posedge mclk) disable iff (sys_rst)
    do_write && wr_word == psrc_pkg::OFS_CTRL_TWO && st_r.w_strb == 4'hF
    |=> ((st_r.ctrl_two ^ $past(st_r.w_data)) & cap_four
         & psrc_pkg::CTRL_TWO_WMASK) == 32'h0)
    else $error("second register write did not land");
  // Unmapped words answer with an error, mapped ones with okay
  a_bad_write: assert property (
    @(posedge mclk) disable iff (sys_rst)
    do_write && !wr_mapped |=> s_axi_bresp == psrc_pkg::RESP_SLVERR)
    else $error("unmapped write not answered with error");
  a_good_write: assert property (
    @(posedge mclk) disable iff (sys_rst)
    do_write && wr_mapped |=> s_axi_bresp == psrc_pkg::RESP_OKAY)
    else $error("mapped write answered with error");
  a_bad_rdata: assert property (
    @(posedge mclk) disable iff (sys_rst)
    s_axi_rvalid && s_axi_rresp == psrc_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0)
    else $error("unmapped read returned data");
  // Reads return the word as stored before the taking edge
  a_read_one: assert property (
    @(posedge mclk) disable iff (sys_rst)
    s_axi_arvalid && s_axi_arready && rd_word == psrc_pkg::OFS_CTRL_ONE
    |=> s_axi_rdata == $past(st_r.ctrl_one))
    else $error("first register read returned wrong word");
  a_read_two: assert property (
    @(posedge mclk) disable iff (sys_rst)
    s_axi_arvalid && s_axi_arready && rd_word == psrc_pkg::OFS_CTRL_TWO
    |=> s_axi_rdata == $past(st_r.ctrl_two))
    else $error("second register read returned wrong word");

endmodule : psrc_top

// >>> psrc_pkg.sv
package psrc_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [31:0] BASE_ADDR = 32'h400FE000;
  localparam logic [11:0] OFS_CTRL_ONE = 12'h044;
  localparam logic [11:0] OFS_CTRL_TWO = 12'h048;
  localparam logic [11:0] OFS_CAP_FOUR = 12'h04C;
  localparam logic [31:0] CTRL_ONE_RST = 32'h00000000;
  localparam logic [31:0] CTRL_TWO_RST = 32'h00000000;
  localparam logic [31:0] CAP_FOUR_RST = 32'h500000FF;

  // ------------------------------------------------------------
  // Writable field masks
  // ------------------------------------------------------------
  localparam logic [31:0] CTRL_ONE_WMASK = 32'h00001037;
  localparam logic [31:0] CTRL_TWO_WMASK = 32'h500000FF;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_ETHER_PHY = 30;
  localparam int BIT_ETHER_MAC = 28;
  localparam int BIT_PORT_H = 7;
  localparam int BIT_PORT_A = 0;
  localparam int BIT_TWOWIRE_ZERO = 12;
  localparam int BIT_SYNCSERIAL_ONE = 5;
  localparam int BIT_SYNCSERIAL_ZERO = 4;
  localparam int BIT_ASYNC_TWO = 2;
  localparam int BIT_ASYNC_ONE = 1;
  localparam int BIT_ASYNC_ZERO = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Peripheral reset outputs
  typedef struct packed {
    logic ether_phy;
    logic ether_mac;
    logic [7:0] port;
    logic twowire_zero;
    logic [1:0] syncserial;
    logic [2:0] async_serial;
  } psrc_resets_t;

endpackage : psrc_pkg

// >>> psrc_periph_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Far side: peripheral units taking software resets
// ------------------------------------------------------------
module psrc_periph_model (
  input wire psrc_pkg::psrc_resets_t periph_rst,
  output psrc_pkg::psrc_resets_t in_reset
);
  // A unit stays held while its line is high, runs once it drops
  assign in_reset = periph_rst;
endmodule : psrc_periph_model

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
  // Some capability bits off, so the write gating shows at the ports
  localparam logic [31:0] CAP_MASK = 32'h500000A5;
  localparam logic [11:0] ONE = psrc_pkg::OFS_CTRL_ONE;
  localparam logic [11:0] TWO = psrc_pkg::OFS_CTRL_TWO;
  logic mclk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, val;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  psrc_pkg::psrc_resets_t periph_rst, in_reset, exp_rst;
  int num_errors = 0;
  int num_checks = 0;

  psrc_top #(.CAP_FOUR_VAL(CAP_MASK)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph_rst(periph_rst));
  psrc_periph_model periph_u (.periph_rst(periph_rst), .in_reset(in_reset));

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // Ready is sampled mid-cycle; it only moves on rising edges
  task axi_wr(input logic [11:0] ofs, input logic [31:0] d,
    input logic [3:0] s);
    logic aw_t;
    logic w_t;
    @(posedge mclk);
    awaddr <= psrc_pkg::BASE_ADDR | {20'h0, ofs};
    awvalid <= 1'h1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'h1;
    bready <= 1'h1;
    @(negedge mclk);
    while (awvalid || wvalid)
    begin
      aw_t = awready;
      w_t = wready;
      @(posedge mclk);
      if (aw_t) awvalid <= 1'h0;
      if (w_t) wvalid <= 1'h0;
      @(negedge mclk);
    end
    while (!bvalid) @(negedge mclk);
    resp = bresp;
    @(posedge mclk);
    bready <= 1'h0;
  endtask : axi_wr

  task axi_rd(input logic [11:0] ofs);
    @(posedge mclk);
    araddr <= psrc_pkg::BASE_ADDR | {20'h0, ofs};
    arvalid <= 1'h1;
    rready <= 1'h1;
    @(negedge mclk);
    while (!arready) @(negedge mclk);
    @(posedge mclk);
    arvalid <= 1'h0;
    @(negedge mclk);
    while (!rvalid) @(negedge mclk);
    val = rdata;
    resp = rresp;
    @(posedge mclk);
    rready <= 1'h0;
  endtask : axi_rd

  task test_done;
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    test_done();
  end

  initial
  begin
    sys_rst = 1'h1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'h0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'h0;
    axi_rd(ONE);
    chk("ctrl_one", 32'h00000000, val);
    axi_rd(TWO);
    chk("ctrl_two", psrc_pkg::CTRL_TWO_RST, val);
    chk("in_reset", 32'h0, 32'(in_reset));
    // Set everything; reserved and gated bits must stay clear
    axi_wr(ONE, 32'hFFFFFFFF, 4'hF);
    chk("bresp", 32'(psrc_pkg::RESP_OKAY), 32'(resp));
    axi_rd(ONE);
    chk("ctrl_one", 32'h00001037, val);
    axi_wr(TWO, 32'hFFFFFFFF, 4'hF);
    chk("bresp", 32'(psrc_pkg::RESP_OKAY), 32'(resp));
    axi_rd(TWO);
    chk("ctrl_two", 32'h500000A5, val);
    repeat (2) @(negedge mclk);
    exp_rst = '{1'h1, 1'h1, 8'hA5, 1'h1, 2'h3, 3'h7};
    chk("in_reset", 32'(exp_rst), 32'(in_reset));
    // Read-modify-write keeps reserved bits as read, drops port A
    axi_rd(TWO);
    axi_wr(TWO, val & 32'hFFFFFFFE, 4'hF);
    axi_rd(TWO);
    chk("ctrl_two", 32'h500000A4, val);
    // Lowest byte only: the unit bits up top must survive
    axi_wr(TWO, 32'h00000000, 4'h1);
    axi_rd(TWO);
    chk("ctrl_two", 32'h50000000, val);
    axi_wr(ONE, 32'h00000000, 4'hF);
    repeat (2) @(negedge mclk);
    exp_rst = '{1'h1, 1'h1, 8'h00, 1'h0, 2'h0, 3'h0};
    chk("in_reset", 32'(exp_rst), 32'(in_reset));
    // Mid-run reset with unit bits set: all must drop to zero
    @(posedge mclk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'h0;
    @(negedge mclk);
    chk("in_reset", 32'h0, 32'(in_reset));
    axi_rd(TWO);
    chk("ctrl_two", psrc_pkg::CTRL_TWO_RST, val);
    axi_rd(ONE);
    chk("ctrl_one", psrc_pkg::CTRL_ONE_RST, val);
    // Unmapped place answers with an error and reads zero
    axi_wr(12'h100, 32'hFFFFFFFF, 4'hF);
    chk("bresp", 32'(psrc_pkg::RESP_SLVERR), 32'(resp));
    axi_rd(12'h100);
    chk("rresp", 32'(psrc_pkg::RESP_SLVERR), 32'(resp));
    chk("rdata", 32'h00000000, val);
    test_done();
  end
endmodule : testbench
